// ==== rtl/video_output_mode_control.v ====
// Output routing, sync options and sleep control of the video encoder,
// with its 2-wire serial register port.
// Assumes timing pulses come from the encoder timing logic on clk and
// that the serial bus pins and the slave vsync pin are asynchronous.
`timescale 1ns/1ps
`include "video_mode_defs.vh"
module video_output_mode_control (
    input  wire       clk,
    input  wire       rst,
    input  wire       scl_pin,
    input  wire       sda_pin_in,
    output reg        sda_pin_out,
    output reg        sda_pin_oe,
    input  wire       first_dac_luma_select,
    input  wire       chroma_on_first_dac,
    input  wire [2:0] dac_power_req,
    input  wire       pal_mode,
    input  wire       line_start,
    input  wire       half_line_start,
    input  wire       field_start,
    input  wire       active_video,
    input  wire       vsync_in_n,
    output reg  [2:0] dac_a_signal_q,
    output reg  [2:0] dac_b_signal_q,
    output reg  [2:0] dac_c_signal_q,
    output reg  [2:0] dac_enable_q,
    output reg  [2:0] rgb_sync_q,
    output reg        pedestal_on_q,
    output reg        edge_filter_on_q,
    output reg        video_path_on_q,
    output reg        master_mode_q,
    output reg        timing_reset_q,
    output reg        vsync_out_n_q,
    output reg        slave_vsync_ok_q,
    output reg  [7:0] output_and_power_mode_q,
    output reg  [7:0] timing_mode_zero_q
);
    localparam ST_IDLE = 9'h001;
    localparam ST_DEV  = 9'h002;
    localparam ST_DACK = 9'h004;
    localparam ST_SUB  = 9'h008;
    localparam ST_SACK = 9'h010;
    localparam ST_WR   = 9'h020;
    localparam ST_WACK = 9'h040;
    localparam ST_RD   = 9'h080;
    localparam ST_RACK = 9'h100;

    wire [2:0] pin_raw;
    wire [2:0] pin_lvl;
    wire       scl_f;
    wire       sda_f;
    wire       vs_in_f;

    reg  [8:0]              st_q;
    reg  [7:0]              sh_q;
    reg  [`BIT_CNT_W-1:0]   bit_q;
    reg  [`SUB_W-1:0]       ptr_q;
    reg                     rd_q;
    reg                     scl_p_q;
    reg                     sda_p_q;
    reg  [7:0]              rdata;
    reg  [`VS_CNT_W-1:0]    vs_cnt_q;
    reg  [`VS_CNT_W-1:0]    vs_len;
    reg  [`VS_CNT_W-1:0]    vin_cnt_q;
    reg                     vin_p_q;

    wire scl_rise  = scl_f & ~scl_p_q;
    wire scl_fall  = ~scl_f & scl_p_q;
    wire bus_start = scl_f & scl_p_q & sda_p_q & ~sda_f;
    wire bus_stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;
    wire byte_done = (bit_q == `BITS_PER_BYTE);

    wire fam   = output_and_power_mode_q[`OM_FAMILY];
    wire cdiff = output_and_power_mode_q[`OM_COLOUR_DIFF];
    wire sleep = output_and_power_mode_q[`OM_SLEEP];
    wire three = output_and_power_mode_q[`OM_THREE_LINE];

    assign pin_raw = {vsync_in_n, sda_pin_in, scl_pin};
    assign scl_f   = pin_lvl[0];
    assign sda_f   = pin_lvl[1];
    assign vs_in_f = pin_lvl[2];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            pin_sync3 #(
                .RST_VAL (1'b1)
            ) u_sync (
                .clk     (clk),
                .rst     (rst),
                .pin     (pin_raw[gi]),
                .level_q (pin_lvl[gi])
            );
        end
    endgenerate

    // Read-back mux; unmapped sub-addresses read as zero
    always @* begin
        case (ptr_q)
            `SUB_OUT_MODE:    rdata = output_and_power_mode_q;
            `SUB_TIMING_ZERO: rdata = timing_mode_zero_q;
            default:          rdata = 8'h00;
        endcase
    end

    // Serial register port; runs regardless of sleep
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q                    <= ST_IDLE;
            sh_q                    <= 8'h00;
            bit_q                   <= {`BIT_CNT_W{1'b0}};
            ptr_q                   <= {`SUB_W{1'b0}};
            rd_q                    <= 1'b0;
            scl_p_q                 <= 1'b1;
            sda_p_q                 <= 1'b1;
            sda_pin_out             <= 1'b0;
            sda_pin_oe              <= 1'b0;
            output_and_power_mode_q <= `OUT_MODE_RST;
            timing_mode_zero_q      <= `TIMING_ZERO_RST;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
            if (bus_start) begin
                st_q       <= ST_DEV;
                bit_q      <= {`BIT_CNT_W{1'b0}};
                sda_pin_oe <= 1'b0;
            end else if (bus_stop) begin
                st_q       <= ST_IDLE;
                sda_pin_oe <= 1'b0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        sda_pin_oe <= 1'b0;
                    end
                    ST_DEV, ST_SUB, ST_WR: begin
                        if (scl_rise && !byte_done) begin
                            sh_q  <= {sh_q[6:0], sda_f};
                            bit_q <= bit_q + 1'b1;
                        end else if (scl_fall && byte_done) begin
                            bit_q <= {`BIT_CNT_W{1'b0}};
                            if (st_q == ST_DEV) begin
                                if (sh_q[7:1] == `DEV_ADDR) begin
                                    rd_q       <= sh_q[0];
                                    sda_pin_oe <= 1'b1;
                                    st_q       <= ST_DACK;
                                end else begin
                                    st_q <= ST_IDLE;
                                end
                            end else if (st_q == ST_SUB) begin
                                ptr_q      <= sh_q[`SUB_W-1:0];
                                sda_pin_oe <= 1'b1;
                                st_q       <= ST_SACK;
                            end else begin
                                // Writes accepted in sleep too
                                case (ptr_q)
                                    `SUB_OUT_MODE: begin
                                        // Full byte kept, top bit is host's duty
                                        output_and_power_mode_q <= sh_q;
                                    end
                                    `SUB_TIMING_ZERO: begin
                                        timing_mode_zero_q <= sh_q;
                                    end
                                    default: begin
                                    end
                                endcase
                                sda_pin_oe <= 1'b1;
                                st_q       <= ST_WACK;
                            end
                        end
                    end
                    ST_DACK: begin
                        if (scl_fall) begin
                            if (rd_q) begin
                                sh_q       <= {rdata[6:0], 1'b0};
                                sda_pin_oe <= ~rdata[7];
                                bit_q      <= 4'h1;
                                st_q       <= ST_RD;
                            end else begin
                                sda_pin_oe <= 1'b0;
                                st_q       <= ST_SUB;
                            end
                        end
                    end
                    ST_SACK: begin
                        if (scl_fall) begin
                            sda_pin_oe <= 1'b0;
                            st_q       <= ST_WR;
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            // Auto-increment for burst writes
                            ptr_q      <= ptr_q + 1'b1;
                            sda_pin_oe <= 1'b0;
                            st_q       <= ST_WR;
                        end
                    end
                    ST_RD: begin
                        if (scl_fall) begin
                            if (byte_done) begin
                                sda_pin_oe <= 1'b0;
                                st_q       <= ST_RACK;
                            end else begin
                                sda_pin_oe <= ~sh_q[7];
                                sh_q       <= {sh_q[6:0], 1'b0};
                                bit_q      <= bit_q + 1'b1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_f) begin
                                st_q <= ST_IDLE;
                            end else begin
                                ptr_q <= ptr_q + 1'b1;
                            end
                        end else if (scl_fall) begin
                            sh_q       <= {rdata[6:0], 1'b0};
                            sda_pin_oe <= ~rdata[7];
                            bit_q      <= 4'h1;
                            st_q       <= ST_RD;
                        end
                    end
                    default: begin
                        st_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Routing latched at line boundaries so no line mixes signal types
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_a_signal_q <= `SIG_CVBS;
            dac_b_signal_q <= `SIG_CVBS;
            dac_c_signal_q <= `SIG_C;
        end else if (line_start) begin
            dac_b_signal_q <= !fam ? `SIG_CVBS : (cdiff ? `SIG_PB : `SIG_B);
            dac_c_signal_q <= !fam ? `SIG_C : (cdiff ? `SIG_PR : `SIG_R);
            if (first_dac_luma_select) begin
                dac_a_signal_q <= (fam && !cdiff) ? `SIG_G : `SIG_Y;
            end else begin
                dac_a_signal_q <= chroma_on_first_dac ? `SIG_C : `SIG_CVBS;
            end
        end
    end

    // Power, sync and filter controls
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_enable_q     <= 3'h0;
            rgb_sync_q       <= 3'h0;
            pedestal_on_q    <= 1'b0;
            edge_filter_on_q <= 1'b0;
            video_path_on_q  <= 1'b0;
            master_mode_q    <= 1'b0;
            timing_reset_q   <= 1'b0;
        end else begin
            video_path_on_q  <= ~sleep;
            dac_enable_q     <= dac_power_req & {3{~sleep}};
            // Green always carries sync in RGB; bit extends it to all three
            if (fam && !cdiff) begin
                rgb_sync_q <= output_and_power_mode_q[`OM_SYNC_ALL] ? 3'h7 : 3'h2;
            end else begin
                rgb_sync_q <= 3'h0;
            end
            pedestal_on_q    <= output_and_power_mode_q[`OM_PEDESTAL] & ~pal_mode;
            edge_filter_on_q <= output_and_power_mode_q[`OM_EDGE_FILTER]
                                & ~active_video;
            master_mode_q    <= timing_mode_zero_q[`TM_MASTER];
            timing_reset_q   <= timing_mode_zero_q[`TM_COUNTER_RESET];
        end
    end

    // Vertical sync length in half lines
    always @* begin
        if (three) begin
            vs_len = pal_mode ? `VS_HALF_PAL_LONG : `VS_HALF_NTSC_LONG;
        end else begin
            vs_len = `VS_HALF_SHORT;
        end
    end

    // Master vsync generation
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            vs_cnt_q      <= {`VS_CNT_W{1'b0}};
            vsync_out_n_q <= 1'b1;
        end else begin
            if (sleep || !timing_mode_zero_q[`TM_MASTER]) begin
                vs_cnt_q <= {`VS_CNT_W{1'b0}};
            end else if (field_start) begin
                vs_cnt_q <= vs_len;
            end else if (half_line_start && vs_cnt_q != {`VS_CNT_W{1'b0}}) begin
                vs_cnt_q <= vs_cnt_q - 1'b1;
            end
            vsync_out_n_q <= (vs_cnt_q == {`VS_CNT_W{1'b0}});
        end
    end

    // Slave vsync length check, comparing the source's length against vs_len
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            vin_cnt_q        <= {`VS_CNT_W{1'b0}};
            vin_p_q          <= 1'b1;
            slave_vsync_ok_q <= 1'b0;
        end else begin
            vin_p_q <= vs_in_f;
            if (vs_in_f) begin
                vin_cnt_q <= {`VS_CNT_W{1'b0}};
            end else if (half_line_start && vin_cnt_q != {`VS_CNT_W{1'b1}}) begin
                vin_cnt_q <= vin_cnt_q + 1'b1;
            end
            if (vs_in_f && !vin_p_q && !timing_mode_zero_q[`TM_MASTER]) begin
                slave_vsync_ok_q <= (vin_cnt_q == vs_len);
            end
        end
    end
endmodule

// ==== rtl/video_mode_defs.vh ====
// Constants for the video output mode and power control block.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef VIDEO_MODE_DEFS_VH
`define VIDEO_MODE_DEFS_VH

// Serial-bus sub-addresses (five bits)
`define SUB_OUT_MODE      5'h04
`define SUB_TIMING_ZERO   5'h07
`define SUB_W             5

// Device address on the 2-wire bus, value arbitrary
`define DEV_ADDR          7'h2A

// Field positions in output_and_power_mode
`define OM_FAMILY         0
`define OM_COLOUR_DIFF    1
`define OM_SYNC_ALL       2
`define OM_THREE_LINE     3
`define OM_PEDESTAL       4
`define OM_EDGE_FILTER    5
`define OM_SLEEP          6
`define OM_RESERVED       7

// Field positions in timing_mode_zero
`define TM_MASTER         0
`define TM_COUNTER_RESET  7

// Reset values
`define OUT_MODE_RST      8'h00
`define TIMING_ZERO_RST   8'h00

// Signal codes carried on each DAC
`define SIG_CVBS          3'h0
`define SIG_Y             3'h1
`define SIG_C             3'h2
`define SIG_G             3'h3
`define SIG_B             3'h4
`define SIG_R             3'h5
`define SIG_PB            3'h6
`define SIG_PR            3'h7

// Vertical sync lengths in half lines
`define VS_HALF_NTSC_LONG 4'h6
`define VS_HALF_PAL_LONG  4'h5
`define VS_HALF_SHORT     4'h2
`define VS_CNT_W          4

// Serial shift and bit counter
`define BITS_PER_BYTE     4'h8
`define BIT_CNT_W         4

`endif

// ==== rtl/pin_sync3.v ====
// Three-flop synchroniser with agreement filter for one pin.
// Assumes a single clock domain clk with asynchronous active-high rst.
`timescale 1ns/1ps
module pin_sync3 #(
    parameter RST_VAL = 1'b1
) (
    input  wire clk,
    input  wire rst,
    input  wire pin,
    output reg  level_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // First flop feeds only the second, to keep metastability contained
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q    <= RST_VAL;
            s2_q    <= RST_VAL;
            s3_q    <= RST_VAL;
            level_q <= RST_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule

// ==== verif/host_bus_model.sv ====
// Host microcontroller model driving the 2-wire register port.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`include "video_mode_defs.vh"
module host_bus_model #(
    parameter int PHASE = 1000
) (
    output logic scl,
    output logic sda_low,
    input  wire  sda_line
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Ten-clock phases leave room for the pin synchronisers
    task automatic put_bit(input logic b);
        sda_low = !b;
        #PHASE scl = 1'b1;
        #PHASE scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        #PHASE scl = 1'b1;
        #(PHASE / 2) b = sda_line;
        #(PHASE / 2) scl = 1'b0;
    endtask
    task automatic start_cond;
        sda_low = 1'b0;
        #PHASE scl = 1'b1;
        #PHASE sda_low = 1'b1;
        #PHASE scl = 1'b0;
    endtask
    task automatic stop_cond;
        sda_low = 1'b1;
        #PHASE scl = 1'b1;
        #PHASE sda_low = 1'b0;
        #PHASE;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic nack;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(nack);
        ack = !nack;
    endtask
    task automatic write_reg(input logic [4:0] sub, input logic [7:0] d, output logic ack);
        logic a0, a1, a2;
        start_cond();
        send_byte({`DEV_ADDR, 1'b0}, a0);
        send_byte({3'h0, sub}, a1);
        send_byte((sub == `SUB_OUT_MODE) ? (d & 8'h7F) : d, a2);
        stop_cond();
        ack = a0 & a1 & a2;
    endtask
    // Repeated start keeps the pointer set by the sub-address byte
    task automatic read_reg(input logic [4:0] sub, output logic [7:0] d);
        logic a;
        start_cond();
        send_byte({`DEV_ADDR, 1'b0}, a);
        send_byte({3'h0, sub}, a);
        start_cond();
        send_byte({`DEV_ADDR, 1'b1}, a);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop_cond();
    endtask
endmodule

// ==== verif/video_output_mode_control_asserts.sv ====
// Assertion checker for the video output mode control block.
// Assumes it is bound to the block's top module and sees its ports only.
`timescale 1ns/1ps
`include "video_mode_defs.vh"
module video_output_mode_control_asserts (
    input logic       clk,
    input logic       rst,
    input logic       first_dac_luma_select,
    input logic       chroma_on_first_dac,
    input logic [2:0] dac_power_req,
    input logic       pal_mode,
    input logic       line_start,
    input logic       active_video,
    input logic [2:0] dac_a_signal_q,
    input logic [2:0] dac_b_signal_q,
    input logic [2:0] dac_c_signal_q,
    input logic [2:0] dac_enable_q,
    input logic [2:0] rgb_sync_q,
    input logic       pedestal_on_q,
    input logic       edge_filter_on_q,
    input logic       video_path_on_q,
    input logic [7:0] output_and_power_mode_q
);
    wire [7:0] m = output_and_power_mode_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_route_second: assert property (line_start |=> dac_b_signal_q ==
        (!$past(m[0]) ? `SIG_CVBS : $past(m[1]) ? `SIG_PB : `SIG_B)) else $error("dac b route");
    chk_route_third: assert property (line_start |=> dac_c_signal_q ==
        (!$past(m[0]) ? `SIG_C : $past(m[1]) ? `SIG_PR : `SIG_R)) else $error("dac c route");
    chk_route_first: assert property (line_start |=> dac_a_signal_q ==
        ($past(first_dac_luma_select) ? (($past(m[1:0]) == 2'h1) ? `SIG_G : `SIG_Y)
        : ($past(chroma_on_first_dac) ? `SIG_C : `SIG_CVBS))) else $error("dac a route");
    chk_route_hold: assert property (!line_start |=>
        $stable({dac_a_signal_q, dac_b_signal_q, dac_c_signal_q})) else $error("route moved");
    // First edge after reset still shows reset values, so skip it
    chk_dac_enable: assert property (!$past(rst) |-> dac_enable_q ==
        ($past(dac_power_req) & {3{!$past(m[6])}})) else $error("dac enable wrong");
    chk_sleep_path: assert property (!$past(rst) |->
        video_path_on_q == !$past(m[6])) else $error("video path state wrong");
    chk_pedestal_ntsc: assert property (!$past(rst) |->
        pedestal_on_q == ($past(m[4]) && !$past(pal_mode))) else $error("pedestal wrong");
    chk_edge_filter: assert property (!$past(rst) |-> edge_filter_on_q ==
        ($past(m[5]) && !$past(active_video))) else $error("edge filter wrong");
    chk_rgb_sync: assert property ((m[1:0] == 2'h1) |=>
        rgb_sync_q == ($past(m[2]) ? 3'h7 : 3'h2)) else $error("rgb sync wrong");
endmodule
bind video_output_mode_control video_output_mode_control_asserts
    video_output_mode_control_asserts_i (.clk(clk), .rst(rst),
    .first_dac_luma_select(first_dac_luma_select), .chroma_on_first_dac(chroma_on_first_dac),
    .dac_power_req(dac_power_req), .pal_mode(pal_mode), .line_start(line_start),
    .active_video(active_video), .dac_a_signal_q(dac_a_signal_q),
    .dac_b_signal_q(dac_b_signal_q), .dac_c_signal_q(dac_c_signal_q),
    .dac_enable_q(dac_enable_q), .rgb_sync_q(rgb_sync_q), .pedestal_on_q(pedestal_on_q),
    .edge_filter_on_q(edge_filter_on_q), .video_path_on_q(video_path_on_q),
    .output_and_power_mode_q(output_and_power_mode_q));

// ==== verif/video_output_mode_control_tb.sv ====
// Self-checking bench for the video output mode control block.
// Assumes the design, host model and checker files are compiled first.
`timescale 1ns/1ps
`include "video_mode_defs.vh"
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t ns: got %0h expected %0h", $time, got, exp); end end
module video_output_mode_control_tb;
    logic        clk, rst, luma, chr, pal, line_s, half_s, field_s, act, vs_in_n, ack;
    logic [2:0]  pwr;
    logic [7:0]  rd;
    wire         scl, sda_low, sda, sda_o, oe, ped, filt, path, mst, trst, vs_n, vs_ok;
    wire  [2:0]  da, db, dc, den, rgbs;
    wire  [11:0] route = {1'b0, da, 1'b0, db, 1'b0, dc};
    wire  [7:0]  mode_q, tim_q;
    int          err_total, samples_checked, cycles, n;
    // One nibble per DAC, rows indexed by {chroma, family, colour difference, luma}
    logic [11:0] rows [16] = '{12'h002, 12'h102, 12'h002, 12'h102, 12'h045, 12'h345, 12'h067,
        12'h167, 12'h202, 12'h102, 12'h202, 12'h102, 12'h245, 12'h345, 12'h267, 12'h167};
    assign sda = !(sda_low || oe);
    host_bus_model host_bus_model_i (.scl(scl), .sda_low(sda_low), .sda_line(sda));
    video_output_mode_control video_output_mode_control_i (.clk(clk), .rst(rst),
        .scl_pin(scl), .sda_pin_in(sda), .sda_pin_out(sda_o), .sda_pin_oe(oe),
        .first_dac_luma_select(luma), .chroma_on_first_dac(chr), .dac_power_req(pwr),
        .pal_mode(pal), .line_start(line_s), .half_line_start(half_s), .field_start(field_s),
        .active_video(act), .vsync_in_n(vs_in_n), .dac_a_signal_q(da), .dac_b_signal_q(db),
        .dac_c_signal_q(dc), .dac_enable_q(den), .rgb_sync_q(rgbs), .pedestal_on_q(ped),
        .edge_filter_on_q(filt), .video_path_on_q(path), .master_mode_q(mst),
        .timing_reset_q(trst), .vsync_out_n_q(vs_n), .slave_vsync_ok_q(vs_ok),
        .output_and_power_mode_q(mode_q), .timing_mode_zero_q(tim_q));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] sub, input logic [7:0] d);
        host_bus_model_i.write_reg(sub, d, ack);
        tick(1);
        `CHECK(ack, 1'b1)
    endtask
    task automatic half_pulse;
        half_s = 1'b1;
        tick(1);
        half_s = 1'b0;
        tick(3);
    endtask
    task automatic vsync_len(output int k);
        field_s = 1'b1;
        tick(1);
        field_s = 1'b0;
        tick(2);
        k = 0;
        while (vs_n === 1'b0 && k < 20) begin
            half_pulse();
            k++;
        end
    endtask
    task automatic slave_try(input int k, input logic exp);
        vs_in_n = 1'b0;
        tick(6);
        repeat (k) half_pulse();
        tick(6);
        vs_in_n = 1'b1;
        tick(8);
        `CHECK(vs_ok, exp)
    endtask
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Generous ceiling: a full run needs roughly twenty-one thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        rst = 1'b1;
        {luma, chr, pal, line_s, half_s, field_s, act, pwr} = 10'h000;
        vs_in_n = 1'b1;
        tick(10);
        rst = 1'b0;
        tick(2);
        `CHECK(({mode_q, tim_q}), ({`OUT_MODE_RST, `TIMING_ZERO_RST}))
        `CHECK(({path, vs_n, oe}), 3'h6)
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            pwr = i[2:0];
            wr(`SUB_OUT_MODE, {5'h00, i[3], i[1], i[2]});
            {chr, luma, pal, act} = {i[3], i[0], i[0], i[1]};
            tick(2);
            if (i > 0)
                `CHECK(route, rows[i - 1])
            `CHECK(den, i[2:0])
            line_s = 1'b1;
            tick(1);
            line_s = 1'b0;
            tick(2);
            `CHECK(route, rows[i])
            $display("routing row %0d done", i);
        end
        wr(`SUB_OUT_MODE, 8'hBF);
        host_bus_model_i.read_reg(`SUB_OUT_MODE, rd);
        `CHECK(rd, 8'h3F)
        {pal, act} = 2'h0;
        wr(`SUB_OUT_MODE, 8'h35);
        `CHECK(({ped, filt, rgbs}), 5'h1F)
        {pal, act} = 2'h3;
        tick(2);
        `CHECK(({ped, filt, rgbs}), 5'h07)
        wr(`SUB_TIMING_ZERO, 8'h80);
        `CHECK(({trst, mst, sda_o}), 3'h4)
        wr(`SUB_TIMING_ZERO, 8'h01);
        host_bus_model_i.read_reg(`SUB_TIMING_ZERO, rd);
        `CHECK(({rd, mst}), 9'h003)
        host_bus_model_i.read_reg(5'h05, rd);
        `CHECK(rd, 8'h00)
        $display("register test done");
        for (int k = 0; k < 3; k++) begin
            wr(`SUB_OUT_MODE, (k == 2) ? 8'h00 : 8'h08);
            pal = (k == 1);
            tick(2);
            vsync_len(n);
            `CHECK(n, (k == 0) ? 6 : (k == 1) ? 5 : 2)
        end
        wr(`SUB_TIMING_ZERO, 8'h00);
        wr(`SUB_OUT_MODE, 8'h08);
        pal = 1'b0;
        slave_try(6, 1'b1);
        slave_try(5, 1'b0);
        pal = 1'b1;
        slave_try(5, 1'b1);
        $display("vsync test done");
        pwr = 3'h7;
        wr(`SUB_OUT_MODE, 8'h40);
        `CHECK(({path, den}), 4'h0)
        wr(`SUB_TIMING_ZERO, 8'h5A);
        host_bus_model_i.read_reg(`SUB_TIMING_ZERO, rd);
        `CHECK(rd, 8'h5A)
        wr(`SUB_OUT_MODE, 8'h00);
        `CHECK(({path, den}), 4'hF)
        wr(`SUB_OUT_MODE, 8'h40);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        `CHECK(({path, mode_q}), 9'h100)
        $display("sleep test done");
        end_sim();
    end
endmodule
